// ===== core/ssr_status_regs.sv
// Status, error latching, routing and APB register slave of the sensor converter
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
// Register map, byte address is four times the index
// 0x00+2n  channel n upper word: [15:12] routed errors, [11:0] result 27:16
// 0x01+2n  channel n lower word: result 15:0
// 0x18     status, read only
// 0x19     error routing, writable bits f8fd
// 0x1a     single channel select in bits 15:14
// 0x1b     sequence enable in bit 15, channel mask in bits 3:0
// 0x1c     interrupt status, write one to clear, data ready in bit 6
// 0x1d     interrupt mask, same layout as 0x1c
// Unmapped or misaligned addresses answer with pslverr and zero data.
// ----------------------------------------------------------------------
// Status word
// ----------------------------------------------------------------------
// [15:14] source channel of the held errors
// [13:8]  under, over, timeout, amp high, amp low, zero count
// [6]     data ready
// [3:0]   unread results, channel 0 at bit 3
// ----------------------------------------------------------------------
// Limitations
// ----------------------------------------------------------------------
// Read clears act on the edge that loads read data, one edge before the
// master samples it; an event in that cycle still sets its flag.
// Upper and lower data words are not shadowed: a result landing between
// the two reads mixes an old and a new half.
// ----------------------------------------------------------------------
module ssr_status_regs
  import ssr_pkg::*;
(
  input wire logic sys_clk_i, // 20 MHz clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic pready_o, // APB ready
  output logic [31:0] prdata_o, // APB read data
  output logic pslverr_o, // APB error, unmapped address
  input wire logic result_valid_i, // One-cycle pulse, new result
  input wire logic [1:0] evt_chan_i, // Channel of result or fault
  input wire logic [27:0] result_data_i, // Conversion result
  input wire logic [5:0] fault_i, // Fault pulses, order UR OR WD AH AL ZC
  output logic irq_n_pin_o, // Interrupt, active low
  output logic [1:0] single_channel_select_o, // Channel for single mode
  output logic multi_channel_sequence_on_o, // Sequential mode on
  output logic [3:0] seq_channel_mask_o // Channels in the sequence
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [5:0] reg_index(input logic [7:0] a);
    reg_index = a[7:2];
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    logic [5:0] i;
    i = a[7:2];
    addr_mapped = (a[1:0] == 2'b00) &&
      ((i <= SSR_IDX_DATA_LAST) || (i >= SSR_IDX_STATUS && i <= SSR_IDX_IMASK));
  endfunction

  function automatic logic [3:0] chan_bit(input logic [1:0] c);
    chan_bit = 4'h1 << c;
  endfunction

  function automatic logic [15:0] pack_status(input ssr_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[SSR_ST_CHAN_LSB +: 2] = s.src_ch;
    w[SSR_ST_ERR_LSB +: 6] = s.err;
    w[SSR_ST_RESULT_AVAILABLE_FLAG] = s.result_available_flag;
    w[3] = s.unread[0];
    w[2] = s.unread[1];
    w[1] = s.unread[2];
    w[0] = s.unread[3];
    pack_status = w;
  endfunction

  // Reserved and unmapped bits read as zero
  function automatic logic [31:0] read_word(input ssr_state_t s, input logic [7:0] a);
    logic [5:0] i;
    logic [1:0] c;
    logic [31:0] w;
    i = reg_index(a);
    c = i[2:1];
    w = 32'h0000_0000;
    if (!addr_mapped(a)) begin
      w = 32'h0000_0000;
    end else if (i <= SSR_IDX_DATA_LAST) begin
      if (i[0]) begin
        w[15:0] = s.data[c][15:0];
      end else begin
        w[15:12] = s.derr[c];
        w[11:0] = s.data[c][27:16];
      end
    end else begin
      case (i)
        SSR_IDX_STATUS: w[15:0] = pack_status(s);
        SSR_IDX_ROUTE: w[15:0] = s.route;
        SSR_IDX_CONFIG: w[SSR_CFG_CHAN_LSB +: 2] = s.act_ch;
        SSR_IDX_SEQ: begin
          w[SSR_SEQ_ON] = s.seq_on;
          w[3:0] = s.seq_mask;
        end
        SSR_IDX_IST: w[6:0] = s.ist;
        SSR_IDX_IMASK: w[6:0] = s.imask;
        default: w = 32'h0000_0000;
      endcase
    end
    read_word = w;
  endfunction

  function automatic logic [3:0] data_flags(input logic [5:0] f, input logic [15:0] r);
    logic [3:0] g;
    g[3] = f[SSR_E_UR] & r[SSR_RT_OUT_LSB + 4];
    g[2] = f[SSR_E_OR] & r[SSR_RT_OUT_LSB + 3];
    g[1] = f[SSR_E_WD] & r[SSR_RT_OUT_LSB + 2];
    g[0] = (f[SSR_E_AH] & r[SSR_RT_OUT_LSB + 1]) |
           (f[SSR_E_AL] & r[SSR_RT_OUT_LSB]);
    data_flags = g;
  endfunction

  // Sequence bookkeeping: next set of channels seen and whether it is
  // complete. An empty mask never completes, so a sequence with no
  // channels cannot raise data-ready.
  function automatic logic [4:0] seq_step(input logic [3:0] seen, input logic [1:0] c,
    input logic [3:0] m);
    logic [3:0] n;
    logic done;
    n = seen | (chan_bit(c) & m);
    done = (m != 4'h0) && ((n & m) == m);
    if (done) begin
      n = 4'h0;
    end
    seq_step = {done, n};
  endfunction

  // Status and data words are read-only: writing them changes nothing
  function automatic ssr_state_t apply_write(input ssr_state_t s, input logic [5:0] i,
    input logic [31:0] wd);
    ssr_state_t n;
    n = s;
    case (i)
      SSR_IDX_ROUTE: n.route = wd[15:0] & SSR_ROUTE_WMASK;
      SSR_IDX_CONFIG: n.act_ch = wd[SSR_CFG_CHAN_LSB +: 2];
      SSR_IDX_SEQ: begin
        n.seq_on = wd[SSR_SEQ_ON];
        n.seq_mask = wd[3:0];
      end
      SSR_IDX_IST: n.ist = s.ist & ~wd[6:0];
      SSR_IDX_IMASK: n.imask = wd[6:0];
      default: n = s;
    endcase
    apply_write = n;
  endfunction

  function automatic logic is_upper_word(input logic [5:0] i);
    is_upper_word = (i <= SSR_IDX_DATA_LAST) && !i[0];
  endfunction

  function automatic logic irq_level(input logic [6:0] st, input logic [6:0] m);
    irq_level = ~|(st & m);
  endfunction

  ssr_state_t q, d;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic acc;
    logic wr_done;
    logic [5:0] idx;
    logic [1:0] rch;
    logic [5:0] err_new;
    logic [3:0] dflag;
    logic result_available_flag_evt;
    logic [3:0] seen_n;
    acc = 1'b0;
    wr_done = 1'b0;
    idx = 6'h00;
    rch = 2'b00;
    err_new = 6'h00;
    dflag = 4'h0;
    result_available_flag_evt = 1'b0;
    seen_n = 4'h0;
    d = q;

    // ------------------------------------------------------------------
    // APB: answer one cycle into the access phase
    // ------------------------------------------------------------------
    acc = psel_i & penable_i & ~q.pready;
    wr_done = psel_i & penable_i & q.pready & pwrite_i & ~q.pslverr;
    idx = reg_index(paddr_i);
    rch = idx[2:1];
    d.pready = acc;
    if (acc) begin
      d.pslverr = ~addr_mapped(paddr_i);
      d.prdata = read_word(q, paddr_i);
    end

    // ------------------------------------------------------------------
    // Read side effects act on the edge that captures read data,
    // so an event can never slip between the snapshot and the clear
    // ------------------------------------------------------------------
    if (acc && !pwrite_i && addr_mapped(paddr_i)) begin
      if (idx == SSR_IDX_STATUS) begin
        d.err = 6'h00;
        d.src_ch = 2'b00;
        d.result_available_flag = 1'b0;
      end
      if (is_upper_word(idx)) begin
        d.unread[rch] = 1'b0;
        d.derr[rch] = 4'h0;
        if (rch == q.src_ch) begin
          d.err = 6'h00;
          d.src_ch = 2'b00;
        end
      end
    end

    // ------------------------------------------------------------------
    // Writes take effect at the edge where the master sees pready;
    // the status register and data words are read-only
    // ------------------------------------------------------------------
    if (wr_done) begin
      d = apply_write(d, idx, pwdata_i);
    end

    // ------------------------------------------------------------------
    // Error latching: events set after the clears, so a set wins
    // ------------------------------------------------------------------
    err_new = fault_i & q.route[SSR_RT_INT_LSB +: 6];
    if (|err_new) begin
      if (d.err == 6'h00) begin
        d.src_ch = evt_chan_i;
      end
      d.err = d.err | err_new;
    end

    // ------------------------------------------------------------------
    // Errors marked in the channel's data word
    // ------------------------------------------------------------------
    dflag = data_flags(fault_i, q.route);
    d.derr[evt_chan_i] = d.derr[evt_chan_i] | dflag;

    // ------------------------------------------------------------------
    // Results, unread tracking and data-ready
    // ------------------------------------------------------------------
    seen_n = q.seen;
    if (result_valid_i) begin
      d.data[evt_chan_i] = result_data_i;
      d.unread[evt_chan_i] = 1'b1;
      if (q.seq_on) begin
        {result_available_flag_evt, seen_n} = seq_step(q.seen, evt_chan_i, q.seq_mask);
      end else begin
        result_available_flag_evt = (evt_chan_i == q.act_ch);
      end
    end
    // Leaving or entering sequence mode restarts the collection
    if (wr_done && idx == SSR_IDX_SEQ) begin
      seen_n = 4'h0;
    end
    d.seen = seen_n;
    result_available_flag_evt = result_available_flag_evt & q.route[SSR_RT_RESULT_AVAILABLE_FLAG];
    if (result_available_flag_evt) begin
      d.result_available_flag = 1'b1;
    end

    // ------------------------------------------------------------------
    // Interrupt status is sticky; a new event beats a same-cycle clear
    // ------------------------------------------------------------------
    d.ist = d.ist | {result_available_flag_evt, err_new};
    d.irq_n = irq_level(d.ist, d.imask);

    // ------------------------------------------------------------------
    // Reset loads every field by name, so a new field needs its own line here
    // ------------------------------------------------------------------
    if (!rst_n_i) begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
      d.irq_n = 1'b1;
      d.src_ch = 2'b00;
      d.err = 6'h00;
      d.result_available_flag = 1'b0;
      d.unread = 4'h0;
      d.seen = 4'h0;
      d.route = SSR_ROUTE_RST;
      d.act_ch = SSR_CHAN_RST;
      d.seq_on = 1'b0;
      d.seq_mask = SSR_SEQ_MASK_RST;
      d.ist = 7'h00;
      d.imask = SSR_IMASK_RST;
      d.data = '0;
      d.derr = '0;
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    q <= d;
  end

  // --------------------------------------------------------------------
  // Outputs, all straight from the state register
  // --------------------------------------------------------------------
  assign pready_o = q.pready;
  assign prdata_o = q.prdata;
  assign pslverr_o = q.pslverr;
  assign irq_n_pin_o = q.irq_n;
  assign single_channel_select_o = q.act_ch;
  assign multi_channel_sequence_on_o = q.seq_on;
  assign seq_channel_mask_o = q.seq_mask;

endmodule
`default_nettype wire

// ===== common/ssr_pkg.sv
// Constants and state type of the sensor status and error reporting block
package ssr_pkg;
  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [5:0] SSR_IDX_DATA0 = 6'h00;
  localparam logic [5:0] SSR_IDX_DATA_LAST = 6'h07;
  localparam logic [5:0] SSR_IDX_STATUS = 6'h18;
  localparam logic [5:0] SSR_IDX_ROUTE = 6'h19;
  localparam logic [5:0] SSR_IDX_CONFIG = 6'h1a;
  localparam logic [5:0] SSR_IDX_SEQ = 6'h1b;
  localparam logic [5:0] SSR_IDX_IST = 6'h1c;
  localparam logic [5:0] SSR_IDX_IMASK = 6'h1d;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int SSR_ST_CHAN_LSB = 14;
  localparam int SSR_ST_ERR_LSB = 8;
  localparam int SSR_ST_RESULT_AVAILABLE_FLAG = 6;
  localparam int SSR_RT_OUT_LSB = 11;
  localparam int SSR_RT_INT_LSB = 2;
  localparam int SSR_RT_RESULT_AVAILABLE_FLAG = 0;
  localparam int SSR_CFG_CHAN_LSB = 14;
  localparam int SSR_SEQ_ON = 15;
  localparam int SSR_RESULT_AVAILABLE_FLAG_IST = 6;
  // Error vector order: under, over, timeout, amp high, amp low, zero count
  localparam int SSR_E_UR = 5;
  localparam int SSR_E_OR = 4;
  localparam int SSR_E_WD = 3;
  localparam int SSR_E_AH = 2;
  localparam int SSR_E_AL = 1;
  localparam int SSR_E_ZC = 0;
  // Writable bits of the routing register
  localparam logic [15:0] SSR_ROUTE_WMASK = 16'hf8fd;
  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] SSR_ROUTE_RST = 16'h0000;
  localparam logic [1:0] SSR_CHAN_RST = 2'h0;
  localparam logic [3:0] SSR_SEQ_MASK_RST = 4'h3;
  localparam logic [6:0] SSR_IMASK_RST = 7'h00;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq_n;
    logic [1:0] src_ch;
    logic [5:0] err;
    logic result_available_flag;
    logic [3:0] unread;
    logic [3:0] seen;
    logic [15:0] route;
    logic [1:0] act_ch;
    logic seq_on;
    logic [3:0] seq_mask;
    logic [6:0] ist;
    logic [6:0] imask;
    logic [3:0][27:0] data;
    logic [3:0][3:0] derr;
  } ssr_state_t;
endpackage

// ===== verif/ssr_event_src.sv
// Conversion-core stand-in issuing result and fault pulses
`timescale 1ns/1ps
`default_nettype none
module ssr_event_src (
  input wire logic clk_i, // Clock
  output logic vld_o = 1'b0, // Result pulse
  output logic [1:0] ch_o = 2'h0, // Channel
  output logic [27:0] dat_o = 28'h0, // Result
  output logic [5:0] flt_o = 6'h0 // Faults
);
  // Data is inverted after the pulse so a stale value never matches
  task automatic send(input logic [1:0] c, input logic v, input logic [27:0] d,
    input logic [5:0] f);
    @(posedge clk_i);
    vld_o <= v;
    ch_o <= c;
    dat_o <= d;
    flt_o <= f;
    @(posedge clk_i);
    vld_o <= 1'b0;
    flt_o <= 6'h0;
    dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== verif/ssr_status_regs_monitor.sv
// Port assertions of the status and error register block
`timescale 1ns/1ps
`default_nettype none
module ssr_status_regs_monitor (
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset
  input wire logic psel_i, // Select
  input wire logic penable_i, // Enable
  input wire logic pwrite_i, // Direction
  input wire logic pready_o, // Ready
  input wire logic [31:0] prdata_o, // Read data
  input wire logic pslverr_o, // Error
  input wire logic result_valid_i, // Result pulse
  input wire logic [5:0] fault_i, // Faults
  input wire logic irq_n_pin_o // Interrupt
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_setup; psel_i && !penable_i; endsequence
  sequence s_access; psel_i && penable_i; endsequence
  sequence s_answer; !pready_o ##1 pready_o; endsequence
  a_ready_wait: assert property (s_setup ##1 s_access |-> s_answer)
    else $error("ready not after one wait");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than a cycle");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("slverr without ready");
  a_err_nodata: assert property (pslverr_o |-> prdata_o == 32'h0)
    else $error("slverr with data");
  a_upper_zero: assert property (pready_o |-> prdata_o[31:16] == 16'h0)
    else $error("upper read bits set");
  a_irq_fall: assert property ($fell(irq_n_pin_o) |->
    $past(result_valid_i || fault_i != 6'h0 || psel_i && pwrite_i))
    else $error("irq fell without cause");
  a_irq_rise: assert property ($rose(irq_n_pin_o) |-> $past(psel_i && pwrite_i))
    else $error("irq rose without write");
endmodule
bind ssr_status_regs ssr_status_regs_monitor u_mon (.sys_clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .pready_o, .prdata_o, .pslverr_o, .result_valid_i, .fault_i,
  .irq_n_pin_o);
`default_nettype wire

// ===== verif/tb_ssr_status_regs.sv
// Register-level test of the status and error reporting block
`timescale 1ns/1ps
`default_nettype none
module tb_ssr_status_regs import ssr_pkg::*; ;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, pready_o, pslverr_o, irq_n_pin_o, seq_on, vld, err;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [1:0] sel, ch;
  logic [3:0] smask;
  logic [27:0] dat;
  logic [5:0] flt;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  ssr_status_regs DUT (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pready_o, .prdata_o, .pslverr_o, .result_valid_i(vld), .evt_chan_i(ch),
    .result_data_i(dat), .fault_i(flt), .irq_n_pin_o, .single_channel_select_o(sel),
    .multi_channel_sequence_on_o(seq_on), .seq_channel_mask_o(smask));
  ssr_event_src src (.clk_i(sys_clk_i), .vld_o(vld), .ch_o(ch), .dat_o(dat), .flt_o(flt));
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ready is sampled at the rising edge, before that edge's updates land;
  // the request is released at that same edge
  task automatic apb(input logic w, input logic [5:0] idx, input logic [15:0] wd);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= {idx, 2'b00};
    pwdata_i <= {16'h0000, wd};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge sys_clk_i);
  endtask
  task automatic rdc(input string nm, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk(nm, rd, exp);
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(negedge sys_clk_i);
    chk("sel", sel, 32'h0);
    chk("seq", {seq_on, smask}, 32'h3);
    chk("irq", irq_n_pin_o, 32'h1);
    rdc("st", SSR_IDX_STATUS, 32'h0);
    rdc("rt", SSR_IDX_ROUTE, 32'h0);
    apb(1'b1, SSR_IDX_ROUTE, 16'hffff);
    rdc("rt", SSR_IDX_ROUTE, 32'hf8fd);
    apb(1'b1, SSR_IDX_ROUTE, 16'h80fd);
    apb(1'b1, SSR_IDX_CONFIG, 16'h8000);
    chk("sel", sel, 32'h2);
    src.send(2'h2, 1'b1, 28'habcdef1, 6'h20);
    rdc("st", SSR_IDX_STATUS, 32'ha042);
    rdc("st", SSR_IDX_STATUS, 32'h0002);
    rdc("up", 6'h04, 32'h8abc);
    rdc("lo", 6'h05, 32'hdef1);
    rdc("st", SSR_IDX_STATUS, 32'h0);
    apb(1'b1, SSR_IDX_CONFIG, 16'hc000);
    for (int i = 0; i < 6; i++) begin
      src.send(2'h3, 1'b0, 28'h0, 6'h01 << i);
      rdc("flt", SSR_IDX_STATUS, 32'hc000 | (32'h100 << i));
    end
    src.send(2'h3, 1'b0, 28'h0, 6'h04);
    apb(1'b0, 6'h06, 16'h0000);
    rdc("held", SSR_IDX_STATUS, 32'h0);
    apb(1'b1, SSR_IDX_SEQ, 16'h8003);
    chk("seq", {seq_on, smask}, 32'h13);
    src.send(2'h0, 1'b1, 28'h1, 6'h00);
    rdc("sq1", SSR_IDX_STATUS, 32'h0008);
    src.send(2'h1, 1'b1, 28'h2, 6'h00);
    rdc("sq2", SSR_IDX_STATUS, 32'h004c);
    apb(1'b1, SSR_IDX_IMASK, 16'h007f);
    chk("irq", irq_n_pin_o, 32'h0);
    apb(1'b1, SSR_IDX_IST, 16'h007f);
    chk("irq", irq_n_pin_o, 32'h1);
    apb(1'b1, SSR_IDX_ROUTE, 16'h0000);
    src.send(2'h0, 1'b0, 28'h0, 6'h20);
    rdc("gate", SSR_IDX_STATUS, 32'h000c);
    chk("irq", irq_n_pin_o, 32'h1);
    apb(1'b1, SSR_IDX_STATUS, 16'hffff);
    rdc("ro", SSR_IDX_STATUS, 32'h000c);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rdc("rst", SSR_IDX_STATUS, 32'h0);
    rdc("rt", SSR_IDX_ROUTE, 32'h0);
    rdc("nomap", 6'h3f, 32'h0);
    chk("err", err, 32'h1);
    results();
  end
endmodule
`default_nettype wire
